// ### logic/tsd_pkg.sv
// constants, types and register map of the tile status and debug register bank
package tsd_pkg;

  // sizes
  localparam int unsigned NUM_OSC     = 4;
  localparam int unsigned NUM_THREADS = 8;
  localparam int unsigned NUM_BRK     = 4;
  localparam int unsigned NUM_SCRATCH = 8;
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned THR_W       = 3;
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned SSR_W       = 11;
  localparam int unsigned RR_THR_W    = 8;
  localparam int unsigned RR_REG_W    = 5;
  localparam int unsigned CODE_W      = 3;
  localparam int unsigned IDX_W       = 2;
  localparam int unsigned SCR_IDX_W   = 3;
  localparam int unsigned CAUSE_THR_W = 8;

  // register numbers
  localparam logic [7:0] A_OSC_CTRL  = 8'h06;
  localparam logic [7:0] A_OSC_CNT0  = 8'h07;
  localparam logic [7:0] A_OSC_CNT3  = 8'h0A;
  localparam logic [7:0] A_RAM_SIZE  = 8'h0C;
  localparam logic [7:0] A_SSR       = 8'h10;
  localparam logic [7:0] A_SPC       = 8'h11;
  localparam logic [7:0] A_SSP       = 8'h12;
  localparam logic [7:0] A_RR_THREAD = 8'h13;
  localparam logic [7:0] A_RR_REG    = 8'h14;
  localparam logic [7:0] A_CAUSE     = 8'h15;
  localparam logic [7:0] A_INFO      = 8'h16;
  localparam logic [7:0] A_STOP      = 8'h18;
  localparam logic [7:0] A_SCRATCH0  = 8'h20;
  localparam logic [7:0] A_BRK_ADDR0 = 8'h30;
  localparam logic [7:0] A_BRK_CTRL0 = 8'h40;
  localparam logic [7:0] SCR_MASK    = 8'hF8;
  localparam logic [7:0] BRK_MASK    = 8'hFC;
  localparam logic [7:0] CFG_SCRATCH0 = 8'h20;

  // field positions
  localparam int unsigned OSC_CORE_BIT  = 1;
  localparam int unsigned OSC_PERI_BIT  = 0;
  localparam int unsigned CAUSE_THR_LSB = 8;
  localparam int unsigned CAUSE_IDX_LSB = 16;
  localparam int unsigned BRK_EN_BIT    = 0;
  localparam int unsigned BRK_NE_BIT    = 1;
  localparam int unsigned BRK_THR_LSB   = 16;
  localparam int unsigned RAM_LSB       = 2;

  // writable bits of the saved status word; bit 8 is read-only
  localparam logic [10:0] SSR_WR_MASK = 11'h6DF;
  localparam logic [10:0] SSR_RD_MASK = 11'h7DF;

  // cause codes
  localparam logic [2:0] CAUSE_NONE   = 3'h0;
  localparam logic [2:0] CAUSE_HOST   = 3'h1;
  localparam logic [2:0] CAUSE_DEBUG_CALL_INSTRUCTION  = 3'h2;
  localparam logic [2:0] CAUSE_IBRK   = 3'h3;
  localparam logic [2:0] CAUSE_DWATCH = 3'h4;
  localparam logic [2:0] CAUSE_RWATCH = 3'h5;

  // reset values and size word
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;
  localparam logic [31:0] RAM_SIZE_BYTES = 32'h0008_0000;

  typedef enum logic {DBG_RUN, DBG_HALT} tsd_dbg_state_e;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } tsd_acc_s;

  typedef struct packed {
    logic [2:0]  thread;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [10:0] sr;
  } tsd_issue_s;

  typedef struct packed {
    logic        resource;
    logic [1:0]  idx;
    logic [2:0]  thread;
    logic [31:0] info;
  } tsd_watch_s;

endpackage

// ### logic/tsd_regs.sv
// tile status and debug register bank with ring oscillator counters and breakpoints
//
// Function
// - four ring oscillator counters, started and stopped from the control register
// - control bit 1 enables core oscillators, bit 0 peripheral; reset zero
// - each counter reads as 16 bits at registers 0x07 to 0x0A
// - counter values survive system reset
// - oscillator edges cross into the tile clock through two flip-flops
// - read-only word gives RAM size in bytes, low two bits zero
// - status word of interrupted thread captured on debugger entry
// - program counter and stack pointer captured on entry, debugger read/write
// - remote register read uses 8-bit thread and 5-bit register operands
// - cause code in bits 2:0, host 1, call 2, breakpoint 3, watch 4/5
// - bits 17:16 hold lowest triggering breakpoint index or watch index, zero for host and call
// - bits 15:8 hold triggering thread number, zero for host requests
// - info register takes watch address or resource identifier
// - set stop bits keep threads halted outside debug mode
// - eight scratch words shared with tile configuration access
// - four breakpoint addresses compared with issued program counter
// - breakpoint control bits 23:16 enable breakpoint per thread
// - bit 0 enables breakpoint, bit 1 selects equal or not equal
`timescale 1ns/1ps
`default_nettype none
module tsd_regs
  import tsd_pkg::*;
(
  // clock and reset
  input  wire logic                   SYS_CLK,
  input  wire logic                   SRST,
  // processor status access
  input  wire tsd_acc_s               PS_CMD,
  output var  logic [DATA_W-1:0]      PS_RDATA,
  output var  logic                   PS_ACK,
  // tile configuration access
  input  wire tsd_acc_s               CFG_CMD,
  output var  logic [DATA_W-1:0]      CFG_RDATA,
  output var  logic                   CFG_ACK,
  // ring oscillators
  input  wire logic [NUM_OSC-1:0]     OSC_IN,
  output var  logic [1:0]             OSC_EN,
  // instruction issue
  input  wire logic                   ISSUE_VALID,
  input  wire tsd_issue_s             ISSUE,
  // debug sources
  input  wire logic                   HOST_DBG_REQ,
  input  wire logic                   DEBUG_CALL_INSTRUCTION_VALID,
  input  wire logic                   WATCH_HIT,
  input  wire tsd_watch_s             WATCH,
  input  wire logic                   DBG_RETURN,
  // debug outputs
  output var  logic                   DBG_IRQ,
  output var  logic                   DBG_MODE,
  output var  logic [NUM_THREADS-1:0] THREAD_STOP,
  output var  logic [RR_THR_W-1:0]    RREAD_THREAD,
  output var  logic [RR_REG_W-1:0]    RREAD_REG
);

  tsd_dbg_state_e            state_q;
  tsd_dbg_state_e            state_d;
  logic [1:0]                osc_ctrl_q;
  logic [NUM_OSC-1:0]        osc_s1_q;
  logic [NUM_OSC-1:0]        osc_s2_q;
  logic [NUM_OSC-1:0]        osc_prev_q;
  // counters power up at zero and are kept through system reset
  logic [CNT_W-1:0]          osc_cnt_q [NUM_OSC] = '{default: '0};
  logic [SSR_W-1:0]          ssr_q;
  logic [DATA_W-1:0]         spc_q;
  logic [DATA_W-1:0]         ssp_q;
  logic [RR_THR_W-1:0]       rr_thr_q;
  logic [RR_REG_W-1:0]       rr_reg_q;
  logic [CODE_W-1:0]         cause_code_q;
  logic [CAUSE_THR_W-1:0]    cause_thr_q;
  logic [IDX_W-1:0]          cause_idx_q;
  logic [DATA_W-1:0]         info_q;
  logic [NUM_THREADS-1:0]    stop_q;
  logic [DATA_W-1:0]         scratch_q [NUM_SCRATCH];
  logic [DATA_W-1:0]         brk_addr_q [NUM_BRK];
  logic [NUM_THREADS-1:0]    brk_thr_q [NUM_BRK];
  logic [NUM_BRK-1:0]        brk_en_q;
  logic [NUM_BRK-1:0]        brk_ne_q;
  logic [DATA_W-1:0]         ps_rdata_q;
  logic                      ps_ack_q;
  logic [DATA_W-1:0]         cfg_rdata_q;
  logic                      cfg_ack_q;
  logic                      irq_q;
  logic [NUM_THREADS-1:0]    thread_stop_q;

  // access decode
  wire       in_debug   = (state_q == DBG_HALT);
  wire       ps_rd      = PS_CMD.req & ~PS_CMD.wr;
  wire       ps_wr      = PS_CMD.req & PS_CMD.wr;
  wire       ps_dwr     = ps_wr & in_debug;
  wire [7:0] pa         = PS_CMD.addr;
  wire [DATA_W-1:0] pw  = PS_CMD.wdata;
  wire       hit_octl   = (pa == A_OSC_CTRL);
  wire       hit_cnt    = (pa >= A_OSC_CNT0) && (pa <= A_OSC_CNT3);
  wire [7:0] cnt_off    = pa - A_OSC_CNT0;
  wire [IDX_W-1:0] cnt_idx = cnt_off[IDX_W-1:0];
  wire       hit_ram    = (pa == A_RAM_SIZE);
  wire       hit_ssr    = (pa == A_SSR);
  wire       hit_spc    = (pa == A_SPC);
  wire       hit_ssp    = (pa == A_SSP);
  wire       hit_rthr   = (pa == A_RR_THREAD);
  wire       hit_rreg   = (pa == A_RR_REG);
  wire       hit_cause  = (pa == A_CAUSE);
  wire       hit_info   = (pa == A_INFO);
  wire       hit_stop   = (pa == A_STOP);
  wire       hit_scr    = ((pa & SCR_MASK) == A_SCRATCH0);
  wire       hit_baddr  = ((pa & BRK_MASK) == A_BRK_ADDR0);
  wire       hit_bctrl  = ((pa & BRK_MASK) == A_BRK_CTRL0);
  wire [SCR_IDX_W-1:0] scr_idx = pa[SCR_IDX_W-1:0];
  wire [IDX_W-1:0]     brk_idx = pa[IDX_W-1:0];
  wire       cfg_wr     = CFG_CMD.req & CFG_CMD.wr;
  wire       cfg_hit    = ((CFG_CMD.addr & SCR_MASK) == CFG_SCRATCH0);
  wire [SCR_IDX_W-1:0] cfg_idx = CFG_CMD.addr[SCR_IDX_W-1:0];

  // breakpoint match per entry
  logic [NUM_BRK-1:0] brk_fire;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BRK; gi++) begin : g_brk
      wire pc_eq = (ISSUE.pc == brk_addr_q[gi]);
      assign brk_fire[gi] = ISSUE_VALID & brk_en_q[gi]
                          & brk_thr_q[gi][ISSUE.thread]
                          & (pc_eq ^ brk_ne_q[gi]);
    end
  endgenerate

  // lowest firing breakpoint wins
  wire [IDX_W-1:0] brk_low = brk_fire[0] ? 2'h0 :
                             brk_fire[1] ? 2'h1 :
                             brk_fire[2] ? 2'h2 : 2'h3;
  wire             brk_any = |brk_fire;

  // debug entry arbitration: host, breakpoint, watchpoint, call
  wire ent_host  = HOST_DBG_REQ;
  wire ent_brk   = ~ent_host & brk_any;
  wire ent_watch = ~ent_host & ~brk_any & WATCH_HIT;
  wire ent_call  = ~ent_host & ~brk_any & ~WATCH_HIT & DEBUG_CALL_INSTRUCTION_VALID & ISSUE_VALID;
  wire entry     = ~in_debug & (ent_host | ent_brk | ent_watch | ent_call);

  wire [CODE_W-1:0] ent_code = ent_host  ? CAUSE_HOST :
                               ent_brk   ? CAUSE_IBRK :
                               ent_watch ? (WATCH.resource ? CAUSE_RWATCH : CAUSE_DWATCH) :
                                           CAUSE_DEBUG_CALL_INSTRUCTION;
  wire [THR_W-1:0]  ent_tsel = ent_watch ? WATCH.thread : ISSUE.thread;
  wire [CAUSE_THR_W-1:0] ent_thr = ent_host ? '0 :
                                   {{(CAUSE_THR_W-THR_W){1'b0}}, ent_tsel};
  wire [IDX_W-1:0]  ent_idx  = ent_brk ? brk_low :
                               ent_watch ? WATCH.idx : '0;

  // debug mode state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DBG_RUN:  if (entry) begin
        state_d = DBG_HALT;
      end
      DBG_HALT: if (DBG_RETURN) begin
        state_d = DBG_RUN;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_q <= DBG_RUN;
      irq_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      irq_q   <= entry;
    end
  end

  // oscillator control
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      osc_ctrl_q <= RST_WORD[1:0];
    end else if (ps_wr && hit_octl) begin
      osc_ctrl_q <= {pw[OSC_CORE_BIT], pw[OSC_PERI_BIT]};
    end
  end

  // oscillator synchronisers and counters, never reset
  generate
    for (gi = 0; gi < NUM_OSC; gi++) begin : g_osc
      localparam bit CORE_SIDE = (gi < NUM_OSC / 2);
      wire osc_on   = CORE_SIDE ? osc_ctrl_q[OSC_CORE_BIT] : osc_ctrl_q[OSC_PERI_BIT];
      wire osc_rise = osc_s2_q[gi] & ~osc_prev_q[gi];
      always_ff @(posedge SYS_CLK) begin
        osc_s1_q[gi]   <= OSC_IN[gi];
        osc_s2_q[gi]   <= osc_s1_q[gi];
        osc_prev_q[gi] <= osc_s2_q[gi];
        if (osc_on && osc_rise) begin
          osc_cnt_q[gi] <= osc_cnt_q[gi] + 1'b1;
        end
      end
    end
  endgenerate

  // saved context and cause
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ssr_q        <= RST_WORD[SSR_W-1:0];
      spc_q        <= RST_WORD;
      ssp_q        <= RST_WORD;
      cause_code_q <= RST_WORD[CODE_W-1:0];
      cause_thr_q  <= RST_WORD[CAUSE_THR_W-1:0];
      cause_idx_q  <= RST_WORD[IDX_W-1:0];
      info_q       <= RST_WORD;
    end else if (entry) begin
      ssr_q        <= ISSUE.sr;
      spc_q        <= ISSUE.pc;
      ssp_q        <= ISSUE.sp;
      cause_code_q <= ent_code;
      cause_thr_q  <= ent_thr;
      cause_idx_q  <= ent_idx;
      if (ent_watch) begin
        info_q <= WATCH.info;
      end
    end else if (ps_dwr) begin
      if (hit_ssr) begin
        ssr_q <= (ssr_q & ~SSR_WR_MASK) | (pw[SSR_W-1:0] & SSR_WR_MASK);
      end
      if (hit_spc) begin
        spc_q <= pw;
      end
      if (hit_ssp) begin
        ssp_q <= pw;
      end
      if (hit_cause) begin
        cause_code_q <= pw[CODE_W-1:0];
        cause_thr_q  <= pw[CAUSE_THR_LSB +: CAUSE_THR_W];
        cause_idx_q  <= pw[CAUSE_IDX_LSB +: IDX_W];
      end
      if (hit_info) begin
        info_q <= pw;
      end
    end
  end

  // remote read operands and stop vector
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      rr_thr_q <= RST_WORD[RR_THR_W-1:0];
      rr_reg_q <= RST_WORD[RR_REG_W-1:0];
      stop_q   <= RST_WORD[NUM_THREADS-1:0];
    end else if (ps_dwr) begin
      if (hit_rthr) begin
        rr_thr_q <= pw[RR_THR_W-1:0];
      end
      if (hit_rreg) begin
        rr_reg_q <= pw[RR_REG_W-1:0];
      end
      if (hit_stop) begin
        stop_q <= pw[NUM_THREADS-1:0];
      end
    end
  end

  // scratch words shared by both access paths
  generate
    for (gi = 0; gi < NUM_SCRATCH; gi++) begin : g_scr
      always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
          scratch_q[gi] <= RST_WORD;
        end else if (ps_dwr && hit_scr && (scr_idx == gi)) begin
          scratch_q[gi] <= pw;
        end else if (cfg_wr && cfg_hit && (cfg_idx == gi)) begin
          scratch_q[gi] <= CFG_CMD.wdata;
        end
      end
    end
  endgenerate

  // breakpoint registers
  generate
    for (gi = 0; gi < NUM_BRK; gi++) begin : g_breg
      always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
          brk_addr_q[gi] <= RST_WORD;
          brk_thr_q[gi]  <= RST_WORD[NUM_THREADS-1:0];
          brk_en_q[gi]   <= 1'b0;
          brk_ne_q[gi]   <= 1'b0;
        end else if (ps_dwr && (brk_idx == gi)) begin
          if (hit_baddr) begin
            brk_addr_q[gi] <= pw;
          end
          if (hit_bctrl) begin
            brk_thr_q[gi] <= pw[BRK_THR_LSB +: NUM_THREADS];
            brk_en_q[gi]  <= pw[BRK_EN_BIT];
            brk_ne_q[gi]  <= pw[BRK_NE_BIT];
          end
        end
      end
    end
  endgenerate

  // read views, reserved bits zero
  wire [DATA_W-1:0] v_octl  = {{(DATA_W-2){1'b0}}, osc_ctrl_q};
  wire [DATA_W-1:0] v_cnt   = {{(DATA_W-CNT_W){1'b0}}, osc_cnt_q[cnt_idx]};
  wire [DATA_W-1:0] v_ram   = {RAM_SIZE_BYTES[DATA_W-1:RAM_LSB], {RAM_LSB{1'b0}}};
  // reserved status bit reads zero
  wire [SSR_W-1:0]  ssr_rd  = ssr_q & SSR_RD_MASK;
  wire [DATA_W-1:0] v_ssr   = {{(DATA_W-SSR_W){1'b0}}, ssr_rd};
  wire [DATA_W-1:0] v_rthr  = {{(DATA_W-RR_THR_W){1'b0}}, rr_thr_q};
  wire [DATA_W-1:0] v_rreg  = {{(DATA_W-RR_REG_W){1'b0}}, rr_reg_q};
  wire [DATA_W-1:0] v_cause = {{(DATA_W-CAUSE_IDX_LSB-IDX_W){1'b0}}, cause_idx_q,
                               cause_thr_q, {(CAUSE_THR_LSB-CODE_W){1'b0}}, cause_code_q};
  wire [DATA_W-1:0] v_stop  = {{(DATA_W-NUM_THREADS){1'b0}}, stop_q};
  wire [DATA_W-1:0] v_bctrl = {{(DATA_W-BRK_THR_LSB-NUM_THREADS){1'b0}}, brk_thr_q[brk_idx],
                               {(BRK_THR_LSB-2){1'b0}}, brk_ne_q[brk_idx], brk_en_q[brk_idx]};

  // open registers read at any time, debug registers only in debug mode
  wire [DATA_W-1:0] rd_open = ({DATA_W{hit_octl}} & v_octl)
                            | ({DATA_W{hit_cnt}}  & v_cnt)
                            | ({DATA_W{hit_ram}}  & v_ram);
  wire [DATA_W-1:0] rd_dbg  = ({DATA_W{hit_ssr}}   & v_ssr)
                            | ({DATA_W{hit_spc}}   & spc_q)
                            | ({DATA_W{hit_ssp}}   & ssp_q)
                            | ({DATA_W{hit_rthr}}  & v_rthr)
                            | ({DATA_W{hit_rreg}}  & v_rreg)
                            | ({DATA_W{hit_cause}} & v_cause)
                            | ({DATA_W{hit_info}}  & info_q)
                            | ({DATA_W{hit_stop}}  & v_stop)
                            | ({DATA_W{hit_scr}}   & scratch_q[scr_idx])
                            | ({DATA_W{hit_baddr}} & brk_addr_q[brk_idx])
                            | ({DATA_W{hit_bctrl}} & v_bctrl);
  wire [DATA_W-1:0] rd_ps   = rd_open | ({DATA_W{in_debug}} & rd_dbg);
  wire [DATA_W-1:0] rd_cfg  = cfg_hit ? scratch_q[cfg_idx] : RST_WORD;

  // answers, one cycle after a request
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ps_ack_q    <= 1'b0;
      ps_rdata_q  <= RST_WORD;
      cfg_ack_q   <= 1'b0;
      cfg_rdata_q <= RST_WORD;
    end else begin
      ps_ack_q    <= PS_CMD.req;
      ps_rdata_q  <= ps_rd ? rd_ps : RST_WORD;
      cfg_ack_q   <= CFG_CMD.req;
      cfg_rdata_q <= (CFG_CMD.req && !CFG_CMD.wr) ? rd_cfg : RST_WORD;
    end
  end

  // stop vector applies only while running
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      thread_stop_q <= RST_WORD[NUM_THREADS-1:0];
    end else begin
      thread_stop_q <= (state_d == DBG_RUN) ? stop_q : '0;
    end
  end

  assign PS_RDATA     = ps_rdata_q;
  assign PS_ACK       = ps_ack_q;
  assign CFG_RDATA    = cfg_rdata_q;
  assign CFG_ACK      = cfg_ack_q;
  assign OSC_EN       = osc_ctrl_q;
  assign DBG_IRQ      = irq_q;
  assign DBG_MODE     = in_debug;
  assign THREAD_STOP  = thread_stop_q;
  assign RREAD_THREAD = rr_thr_q;
  assign RREAD_REG    = rr_reg_q;

endmodule
`default_nettype wire

// ### dv/tsd_regs_monitor.sv
// assertion checker for the tile status and debug register bank
`timescale 1ns/1ps
`default_nettype none
module tsd_regs_monitor
  import tsd_pkg::*;
(
  // clock and reset
  input wire logic                   SYS_CLK,
  input wire logic                   SRST,
  // register access
  input wire tsd_acc_s               PS_CMD,
  input wire logic [DATA_W-1:0]      PS_RDATA,
  input wire logic                   PS_ACK,
  input wire tsd_acc_s               CFG_CMD,
  input wire logic                   CFG_ACK,
  input wire logic [1:0]             OSC_EN,
  // debug
  input wire logic                   ISSUE_VALID,
  input wire logic                   HOST_DBG_REQ,
  input wire logic                   DEBUG_CALL_INSTRUCTION_VALID,
  input wire logic                   DBG_RETURN,
  input wire logic                   DBG_IRQ,
  input wire logic                   DBG_MODE,
  input wire logic [NUM_THREADS-1:0] THREAD_STOP
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  sequence osc_wr_s;
    PS_CMD.req && PS_CMD.wr && PS_CMD.addr == A_OSC_CTRL;
  endsequence
  sequence host_entry_s;
    HOST_DBG_REQ && !DBG_MODE;
  endsequence
  sequence entered_s;
    DBG_IRQ && DBG_MODE ##1 !DBG_IRQ && DBG_MODE;
  endsequence

  ps_ack_a: assert property (PS_ACK == $past(PS_CMD.req))
    else $error("status ack not one cycle after request");
  cfg_ack_a: assert property (CFG_ACK == $past(CFG_CMD.req))
    else $error("config ack not one cycle after request");
  rdata_idle_a: assert property (!PS_ACK |-> PS_RDATA == '0)
    else $error("read data not zero outside ack");
  osc_read_a: assert property (PS_CMD.req && !PS_CMD.wr && PS_CMD.addr == A_OSC_CTRL
    |=> PS_RDATA == {30'h0, OSC_EN}) else $error("oscillator control read wrong");
  osc_write_a: assert property (osc_wr_s |=> OSC_EN == $past(PS_CMD.wdata[1:0]))
    else $error("oscillator enables not written");
  osc_hold_a: assert property (!(PS_CMD.req && PS_CMD.wr && PS_CMD.addr == A_OSC_CTRL)
    |=> $stable(OSC_EN))
    else $error("oscillator enables changed without write");
  ram_size_a: assert property (PS_CMD.req && !PS_CMD.wr && PS_CMD.addr == A_RAM_SIZE
    |=> PS_RDATA == RAM_SIZE_BYTES && PS_RDATA[1:0] == 2'h0) else $error("ram size wrong");
  host_entry_a: assert property (host_entry_s |=> entered_s)
    else $error("host request did not enter debug");
  debug_call_instruction_entry_a: assert property (ISSUE_VALID && DEBUG_CALL_INSTRUCTION_VALID && !DBG_MODE |=> entered_s)
    else $error("debug call did not enter debug");
  irq_once_a: assert property (DBG_IRQ |-> !$past(DBG_MODE))
    else $error("debug interrupt while already in debug");
  stop_quiet_a: assert property (DBG_MODE |-> THREAD_STOP == '0)
    else $error("threads stopped inside debug mode");
  return_a: assert property (DBG_RETURN && DBG_MODE |=> !DBG_MODE)
    else $error("debug mode not left on return");
endmodule

bind tsd_regs tsd_regs_monitor u_tsd_regs_monitor (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .PS_CMD(PS_CMD), .PS_RDATA(PS_RDATA), .PS_ACK(PS_ACK),
  .CFG_CMD(CFG_CMD), .CFG_ACK(CFG_ACK), .OSC_EN(OSC_EN), .ISSUE_VALID(ISSUE_VALID),
  .HOST_DBG_REQ(HOST_DBG_REQ), .DEBUG_CALL_INSTRUCTION_VALID(DEBUG_CALL_INSTRUCTION_VALID), .DBG_RETURN(DBG_RETURN),
  .DBG_IRQ(DBG_IRQ), .DBG_MODE(DBG_MODE), .THREAD_STOP(THREAD_STOP)
);
`default_nettype wire

// ### dv/tsd_osc_model.sv
// free-running ring oscillator stand-in for the four raw oscillator inputs
`timescale 1ns/1ps
`default_nettype none
module tsd_osc_model
  import tsd_pkg::*;
(
  // raw oscillator outputs
  output var logic [NUM_OSC-1:0] osc_out
);
  initial osc_out = 4'h0;
  // each level lasts over two tile clocks, phase unrelated to the tile clock
  for (genvar i = 0; i < NUM_OSC; i++) begin : g_osc
    always #(23 + 4 * i) osc_out[i] = ~osc_out[i];
  end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// self-checking testbench for the tile status and debug register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tsd_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  tsd_acc_s    ps_cmd = '0;
  tsd_acc_s    cfg_cmd = '0;
  tsd_issue_s  issue = '0;
  tsd_watch_s  watch = '0;
  logic        issue_valid = 1'b0;
  logic        host_req = 1'b0;
  logic        debug_call_instruction = 1'b0;
  logic        watch_hit = 1'b0;
  logic        dbg_ret = 1'b0;
  logic [31:0] ps_rdata;
  logic [31:0] cfg_rdata;
  logic        ps_ack;
  logic        cfg_ack;
  logic [3:0]  osc;
  logic [1:0]  osc_en;
  logic        dbg_irq;
  logic        dbg_mode;
  logic [7:0]  stop;
  logic [7:0]  rr_thr;
  logic [4:0]  rr_reg;
  logic [31:0] rd;
  logic [31:0] cnt_save [4];
  int          n_mismatch = 0;
  int          n_compared = 0;

  always #5 sys_clk = ~sys_clk;

  tsd_osc_model u_tsd_osc_model (.osc_out(osc));
  tsd_regs u_tsd_regs (
    .SYS_CLK(sys_clk), .SRST(srst), .PS_CMD(ps_cmd), .PS_RDATA(ps_rdata), .PS_ACK(ps_ack),
    .CFG_CMD(cfg_cmd), .CFG_RDATA(cfg_rdata), .CFG_ACK(cfg_ack), .OSC_IN(osc),
    .OSC_EN(osc_en), .ISSUE_VALID(issue_valid), .ISSUE(issue), .HOST_DBG_REQ(host_req),
    .DEBUG_CALL_INSTRUCTION_VALID(debug_call_instruction), .WATCH_HIT(watch_hit), .WATCH(watch), .DBG_RETURN(dbg_ret),
    .DBG_IRQ(dbg_irq), .DBG_MODE(dbg_mode), .THREAD_STOP(stop), .RREAD_THREAD(rr_thr),
    .RREAD_REG(rr_reg)
  );

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access on either port; ack and data are taken one cycle after the request
  task automatic acc(input bit cfg, input bit wr, input logic [7:0] a, input logic [31:0] wd);
    tsd_acc_s c;
    c = '{req: 1'b1, wr: wr, addr: a, wdata: wd};
    @(negedge sys_clk);
    if (cfg) cfg_cmd = c;
    else ps_cmd = c;
    @(negedge sys_clk);
    rd = cfg ? cfg_rdata : ps_rdata;
    chk("ack", 32'h1, {31'h0, cfg ? cfg_ack : ps_ack});
    ps_cmd = '0;
    cfg_cmd = '0;
  endtask

  task automatic rchk(input string what, input bit cfg, input logic [7:0] a,
                      input logic [31:0] exp);
    acc(cfg, 1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // sources were raised at the last falling edge; look one cycle later
  task automatic step(input string what, input logic [1:0] exp);
    @(negedge sys_clk);
    {issue_valid, host_req, debug_call_instruction, watch_hit} = 4'h0;
    chk(what, {30'h0, exp}, {30'h0, dbg_irq, dbg_mode});
  endtask

  task automatic leave();
    @(negedge sys_clk);
    dbg_ret = 1'b1;
    @(negedge sys_clk);
    dbg_ret = 1'b0;
    chk("mode after return", 32'h0, {31'h0, dbg_mode});
  endtask

  task automatic test_osc_ctrl();
    rchk("osc ctrl reset", 0, A_OSC_CTRL, 32'h0);
    acc(0, 1, A_OSC_CTRL, 32'hFFFF_FFFE);
    rchk("osc ctrl reserved", 0, A_OSC_CTRL, 32'h2);
    chk("osc en", 32'h2, {30'h0, osc_en});
    acc(0, 1, A_RAM_SIZE, 32'hFFFF_FFFF);
    rchk("ram size", 0, A_RAM_SIZE, RAM_SIZE_BYTES);
    rchk("unmapped", 0, 8'h0B, 32'h0);
    $display("test osc ctrl done");
  endtask

  task automatic test_osc_counts();
    acc(0, 1, A_OSC_CTRL, 32'h3);
    repeat (200) @(negedge sys_clk);
    acc(0, 1, A_OSC_CTRL, 32'h1);
    repeat (10) @(negedge sys_clk);
    for (int i = 0; i < 2; i++) begin
      acc(0, 0, A_OSC_CNT0 + 8'(i), 32'h0);
      cnt_save[i] = rd;
    end
    repeat (100) @(negedge sys_clk);
    acc(0, 1, A_OSC_CTRL, 32'h0);
    repeat (10) @(negedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      acc(0, 0, A_OSC_CNT0 + 8'(i), 32'h0);
      chk("count upper", 32'h0, {16'h0, rd[31:16]});
      chk("count ran", 32'h1, {31'h0, rd != 32'h0});
      if (i < 2) chk("core count held", cnt_save[i], rd);
      cnt_save[i] = rd;
    end
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    for (int i = 0; i < 4; i++) rchk("count kept", 0, A_OSC_CNT0 + 8'(i), cnt_save[i]);
    rchk("osc ctrl after reset", 0, A_OSC_CTRL, 32'h0);
    $display("test osc counts done");
  endtask

  task automatic test_host_entry();
    rchk("cause outside debug", 0, A_CAUSE, 32'h0);
    @(negedge sys_clk);
    issue = '{thread: 3'h4, pc: 32'h0000_1234, sp: 32'h0000_5678, sr: 11'h7FF};
    host_req = 1'b1;
    step("host entry", 2'h3);
    rchk("ssr", 0, A_SSR, 32'h7DF);
    rchk("spc", 0, A_SPC, 32'h1234);
    rchk("ssp", 0, A_SSP, 32'h5678);
    rchk("host cause", 0, A_CAUSE, 32'h1);
    acc(0, 1, A_SSR, 32'h0);
    rchk("ssr ro bit", 0, A_SSR, 32'h100);
    acc(0, 1, A_SSP, 32'hCAFE_0001);
    rchk("ssp write", 0, A_SSP, 32'hCAFE_0001);
    acc(0, 1, A_CAUSE, 32'hFFFF_FFFF);
    rchk("cause write", 0, A_CAUSE, 32'h0003_FF07);
    acc(0, 1, A_RR_THREAD, 32'hFFFF_FFFF);
    rchk("rr thread", 0, A_RR_THREAD, 32'hFF);
    acc(0, 1, A_RR_REG, 32'hFFFF_FFFF);
    rchk("rr reg", 0, A_RR_REG, 32'h1F);
    chk("rr outputs", 32'h1FFF, {19'h0, rr_thr, rr_reg});
    acc(0, 1, A_STOP, 32'h0000_01A5);
    rchk("stop vector", 0, A_STOP, 32'hA5);
    acc(0, 1, A_SCRATCH0 + 8'h3, 32'h1234_ABCD);
    rchk("scratch via cfg", 1, CFG_SCRATCH0 + 8'h3, 32'h1234_ABCD);
    acc(1, 1, CFG_SCRATCH0 + 8'h7, 32'h5A5A_0000);
    rchk("scratch via ps", 0, A_SCRATCH0 + 8'h7, 32'h5A5A_0000);
    acc(0, 1, A_BRK_ADDR0 + 8'h2, 32'h1000);
    acc(0, 1, A_BRK_ADDR0 + 8'h3, 32'h1000);
    acc(0, 1, A_BRK_CTRL0 + 8'h2, 32'h0004_0001);
    acc(0, 1, A_BRK_CTRL0 + 8'h3, 32'hFFFF_FFFF);
    rchk("brk ctrl", 0, A_BRK_CTRL0 + 8'h3, 32'h00FF_0003);
    @(negedge sys_clk);
    host_req = 1'b1;
    step("no entry in debug", 2'h1);
    leave();
    chk("stop after return", 32'hA5, {24'h0, stop});
    $display("test host entry done");
  endtask

  task automatic test_sources();
    @(negedge sys_clk);
    issue = '{thread: 3'h1, pc: 32'h1000, sp: 32'h0, sr: 11'h0};
    issue_valid = 1'b1;
    step("brk thread off", 2'h0);
    @(negedge sys_clk);
    issue.thread = 3'h2;
    issue_valid = 1'b1;
    step("brk equal", 2'h3);
    rchk("brk eq cause", 0, A_CAUSE, 32'h0002_0203);
    leave();
    @(negedge sys_clk);
    issue = '{thread: 3'h1, pc: 32'h2000, sp: 32'h0, sr: 11'h0};
    issue_valid = 1'b1;
    step("brk not equal", 2'h3);
    rchk("brk ne cause", 0, A_CAUSE, 32'h0003_0103);
    rchk("brk pc", 0, A_SPC, 32'h2000);
    leave();
    for (int r = 0; r < 2; r++) begin
      @(negedge sys_clk);
      watch = '{resource: 1'(r), idx: 2'h1, thread: 3'h5, info: 32'h0000_ABC0 | 32'(r)};
      watch_hit = 1'b1;
      step("watch entry", 2'h3);
      rchk("watch cause", 0, A_CAUSE, 32'h0001_0504 + 32'(r));
      rchk("watch info", 0, A_INFO, 32'h0000_ABC0 | 32'(r));
      leave();
    end
    @(negedge sys_clk);
    issue = '{thread: 3'h6, pc: 32'h1000, sp: 32'h0, sr: 11'h0};
    issue_valid = 1'b1;
    debug_call_instruction = 1'b1;
    step("debug_call_instruction entry", 2'h3);
    rchk("debug_call_instruction cause", 0, A_CAUSE, 32'h0000_0602);
    rchk("info kept", 0, A_INFO, 32'h0000_ABC1);
    leave();
    $display("test sources done");
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    test_osc_ctrl();
    test_osc_counts();
    test_host_entry();
    test_sources();
    give_verdict();
  end

  initial begin
    #500000;
    n_mismatch++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
`default_nettype wire
